// *** amc_top.sv ***
// amc_top: mode decode, reset and fault control of a four half-bridge pwm power stage.
// assumes pins arrive asynchronously; fault detectors sit on ref_clk.
`timescale 1ns/1ns
`include "amc_map.svh"

module amc_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // device pins
    input wire logic reset_n_pin,
    input wire logic cfg_sel0,
    input wire logic cfg_sel1,
    input wire logic cfg_sel2,
    input wire logic [3:0] pwm_in,
    // protection events on ref_clk
    input wire logic global_fault,
    input wire logic overload_fault,
    // half-bridge gates
    output logic [3:0] hs_on,
    output logic [3:0] ls_on,
    output logic [3:0] pd_en,
    // open-drain fault pin, enable high pulls the line low
    output logic fault_n_o,
    output logic fault_n_oe,
    // status
    output logic dc_prot_en,
    output logic cfg_err
);

    amc_pkg::amc_regs_s r_ff; // all control state
    amc_pkg::amc_regs_s nxt_r; // next control state
    logic [`AMC_PIN_W-1:0] pins; // raw pin vector
    logic [`AMC_PIN_W-1:0] diff23; // stages two and three disagree
    logic rstn; // filtered reset pin
    logic [3:0] pw; // filtered pwm inputs

    // mode pin decode
    function automatic amc_pkg::amc_cfg_s decode(input logic [2:0] m);
        amc_pkg::amc_cfg_s c;
        c = '0;
        case (m)
            `AMC_MODE_AD_DIFF_BTL: begin
                c.differential_input = 1'b1;
                c.arr = amc_pkg::ARR_BTL;
            end
            `AMC_MODE_AD_SING_BTL: begin
                c.arr = amc_pkg::ARR_BTL;
            end
            `AMC_MODE_PS_DIFF_BTL: begin
                c.phase_shifted_modulation = 1'b1;
                c.differential_input = 1'b1;
                c.arr = amc_pkg::ARR_BTL;
            end
            `AMC_MODE_AD_SING_MIX: begin
                c.arr = amc_pkg::ARR_MIX;
            end
            `AMC_MODE_AD_DIFF_PARALLELED_BRIDGED_OUTPUT: begin
                c.differential_input = 1'b1;
                c.arr = amc_pkg::ARR_PARALLELED_BRIDGED_OUTPUT;
            end
            `AMC_MODE_AD_SING_SE: begin
                c.arr = amc_pkg::ARR_SE;
            end
            `AMC_MODE_PS_DIFF_PARALLELED_BRIDGED_OUTPUT: begin
                c.phase_shifted_modulation = 1'b1;
                c.differential_input = 1'b1;
                c.arr = amc_pkg::ARR_PARALLELED_BRIDGED_OUTPUT;
            end
            // phase-shifted with single input, not usable
            default: begin
                c.phase_shifted_modulation = 1'b1;
                c.arr = amc_pkg::ARR_BTL;
            end
        endcase
        c.unsup = c.phase_shifted_modulation & (~c.differential_input
            | (c.arr == amc_pkg::ARR_SE) | (c.arr == amc_pkg::ARR_MIX));
        return c;
    endfunction

    assign pins = {reset_n_pin, cfg_sel2, cfg_sel1, cfg_sel0, pwm_in};
    assign diff23 = r_ff.s2 ^ r_ff.s3;
    assign rstn = r_ff.flt[`AMC_PIN_RSTN];
    assign pw = r_ff.flt[`AMC_PIN_PWM_HI:`AMC_PIN_PWM_LO];

    // next-state logic
    always_comb begin
        nxt_r = r_ff;
        // three-stage pin synchroniser, value taken once stages two and three agree
        nxt_r.s1 = pins;
        nxt_r.s2 = r_ff.s1;
        nxt_r.s3 = r_ff.s2;
        nxt_r.flt = (~diff23 & r_ff.s3) | (diff23 & r_ff.flt);
        case (r_ff.st)
            amc_pkg::ST_HOLD: begin
                nxt_r.cfg = decode(r_ff.flt[`AMC_PIN_SEL_HI:`AMC_PIN_SEL_LO]);
                if (rstn) begin
                    nxt_r.st = r_ff.cfg.unsup ? amc_pkg::ST_UNSUP : amc_pkg::ST_RUN;
                end
            end
            amc_pkg::ST_RUN: begin
                if (!rstn) begin
                    nxt_r.st = amc_pkg::ST_HOLD;
                end else if (global_fault || overload_fault) begin
                    nxt_r.st = amc_pkg::ST_FAULT;
                end
            end
            amc_pkg::ST_FAULT: begin
                // only a reset toggle leaves the latched fault
                if (!rstn) begin
                    nxt_r.st = amc_pkg::ST_HOLD;
                end
            end
            amc_pkg::ST_UNSUP: begin
                if (!rstn) begin
                    nxt_r.st = amc_pkg::ST_HOLD;
                end
            end
            default: begin
                nxt_r.st = amc_pkg::ST_HOLD;
            end
        endcase
        nxt_r.run = (nxt_r.st == amc_pkg::ST_RUN);
        // fault pin pulled low on shutdown
        nxt_r.fault_oe = (nxt_r.st == amc_pkg::ST_FAULT);
        nxt_r.dc_prot = nxt_r.run & ~r_ff.cfg.phase_shifted_modulation;
        nxt_r.cfg_err = (nxt_r.st == amc_pkg::ST_UNSUP);
        // route inputs to bridges per arrangement
        nxt_r.drv = pw;
        case (r_ff.cfg.arr)
            amc_pkg::ARR_BTL: begin
                if (!r_ff.cfg.differential_input) begin
                    nxt_r.drv = {~pw[`AMC_HB_C], pw[`AMC_HB_C], ~pw[`AMC_HB_A], pw[`AMC_HB_A]};
                end
                nxt_r.pd = `AMC_PD_ALL;
            end
            amc_pkg::ARR_PARALLELED_BRIDGED_OUTPUT: begin
                if (r_ff.cfg.differential_input) begin
                    nxt_r.drv = {pw[`AMC_HB_B], pw[`AMC_HB_A], pw[`AMC_HB_B], pw[`AMC_HB_A]};
                end else begin
                    nxt_r.drv = {~pw[`AMC_HB_A], pw[`AMC_HB_A], ~pw[`AMC_HB_A], pw[`AMC_HB_A]};
                end
                nxt_r.pd = `AMC_PD_ALL;
            end
            amc_pkg::ARR_SE: begin
                nxt_r.pd = `AMC_PD_NONE;
            end
            // bridge on a/b from one input, c and d single-ended
            default: begin
                nxt_r.drv = {pw[`AMC_HB_D], pw[`AMC_HB_C], ~pw[`AMC_HB_A], pw[`AMC_HB_A]};
                nxt_r.pd = `AMC_PD_AB;
            end
        endcase
        // pulldowns only while held in reset
        // none at all for an unsupported code
        if (nxt_r.st != amc_pkg::ST_HOLD || r_ff.cfg.unsup) begin
            nxt_r.pd = `AMC_PD_NONE;
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r_ff <= '0;
            r_ff.st <= amc_pkg::ST_HOLD;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // one driver per half-bridge
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_hb
            amc_half_bridge u_hb (
                .ref_clk(ref_clk),
                .rst(rst),
                .run(r_ff.run),
                .drv(r_ff.drv[gi]),
                .pd_req(r_ff.pd[gi]),
                .hs_on(hs_on[gi]),
                .ls_on(ls_on[gi]),
                .pd_en(pd_en[gi])
            );
        end
    endgenerate

    assign fault_n_oe = r_ff.fault_oe;
    assign fault_n_o = 1'b0;
    assign dc_prot_en = r_ff.dc_prot;
    assign cfg_err = r_ff.cfg_err;

    // reset pin released while held
    sequence rel_s;
        (r_ff.st == amc_pkg::ST_HOLD) && rstn;
    endsequence

    sequence run_s;
        ##1 (r_ff.st == amc_pkg::ST_RUN) ##1 (r_ff.run);
    endsequence

    // supported bridged code decoded, then still held one edge later
    sequence held_btl_s;
        (r_ff.st == amc_pkg::ST_HOLD && r_ff.cfg.arr == amc_pkg::ARR_BTL && !r_ff.cfg.unsup)
            ##1 (r_ff.st == amc_pkg::ST_HOLD);
    endsequence

    restart_seq_a: assert property (@(posedge ref_clk) disable iff (rst)
        rel_s ##0 !r_ff.cfg.unsup |-> run_s)
        else $error("no restart after reset release");

    hiz_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        (r_ff.st == amc_pkg::ST_HOLD) |-> ##1 (hs_on == 4'h0 && ls_on == 4'h0))
        else $error("bridge switching while reset held");

    fault_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        !rstn |=> !fault_n_oe)
        else $error("fault output active while reset low");

    fault_report_a: assert property (@(posedge ref_clk) disable iff (rst)
        (r_ff.st == amc_pkg::ST_RUN && rstn && (global_fault || overload_fault)) |=> fault_n_oe)
        else $error("shutdown fault not reported");

    fault_latch_a: assert property (@(posedge ref_clk) disable iff (rst)
        (r_ff.st == amc_pkg::ST_FAULT && rstn) |=> (fault_n_oe && !r_ff.run))
        else $error("latched fault dropped without reset");

    pulldown_btl_a: assert property (@(posedge ref_clk) disable iff (rst)
        held_btl_s |=> (pd_en == 4'hF))
        else $error("bridged pulldowns missing in reset");

    se_nopd_a: assert property (@(posedge ref_clk) disable iff (rst)
        (r_ff.cfg.arr == amc_pkg::ARR_SE) [*2] |=> (pd_en == 4'h0))
        else $error("pulldown in single-ended mode");

    dc_prot_a: assert property (@(posedge ref_clk) disable iff (rst)
        dc_prot_en |-> !r_ff.cfg.phase_shifted_modulation && r_ff.run)
        else $error("dc protection outside complementary run");

    cfg_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        (r_ff.st != amc_pkg::ST_HOLD) |=> $stable(r_ff.cfg))
        else $error("configuration changed during operation");

    unsup_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        (r_ff.st == amc_pkg::ST_UNSUP && rstn) |=> (hs_on == 4'h0 && ls_on == 4'h0 && cfg_err))
        else $error("unsupported mode switching");

endmodule

// *** amc_map.svh ***
// amc_map.svh: named codes and bit positions for the amplifier mode and reset control.
// assumes it is included by the package and by the design files, never compiled alone.
`ifndef AMC_MAP_SVH
`define AMC_MAP_SVH

// mode pin codes {cfg_sel2, cfg_sel1, cfg_sel0}
`define AMC_MODE_AD_DIFF_BTL 3'h0
`define AMC_MODE_AD_SING_BTL 3'h1
`define AMC_MODE_PS_DIFF_BTL 3'h2
`define AMC_MODE_AD_SING_MIX 3'h3
`define AMC_MODE_AD_DIFF_PARALLELED_BRIDGED_OUTPUT 3'h4
`define AMC_MODE_AD_SING_SE 3'h5
`define AMC_MODE_PS_DIFF_PARALLELED_BRIDGED_OUTPUT 3'h6
`define AMC_MODE_PS_SING_BAD 3'h7

// positions inside the synchronised pin vector
`define AMC_PIN_PWM_LO 0
`define AMC_PIN_PWM_HI 3
`define AMC_PIN_SEL_LO 4
`define AMC_PIN_SEL_HI 6
`define AMC_PIN_RSTN 7
`define AMC_PIN_W 8

// half-bridge indices
`define AMC_HB_A 0
`define AMC_HB_B 1
`define AMC_HB_C 2
`define AMC_HB_D 3

// pulldown masks per arrangement while reset is held low
`define AMC_PD_ALL 4'hF
`define AMC_PD_NONE 4'h0
`define AMC_PD_AB 4'h3

`endif

// *** amc_pkg.sv ***
// amc_pkg: types shared by the mode and reset control and its half-bridge driver.
// assumes amc_map.svh is found on the include path.
`include "amc_map.svh"

package amc_pkg;

    // output arrangement of the four half-bridges
    typedef enum logic [1:0] {
        ARR_BTL = 2'h0,
        ARR_PARALLELED_BRIDGED_OUTPUT = 2'h1,
        ARR_SE = 2'h2,
        ARR_MIX = 2'h3
    } amc_arr_e;

    // main control states, one-hot
    typedef enum logic [3:0] {
        ST_HOLD = 4'h1,
        ST_RUN = 4'h2,
        ST_FAULT = 4'h4,
        ST_UNSUP = 4'h8
    } amc_state_e;

    // decoded configuration
    typedef struct packed {
        logic phase_shifted_modulation;
        logic differential_input;
        amc_arr_e arr;
        logic unsup;
    } amc_cfg_s;

    // state of the main control
    typedef struct packed {
        logic [`AMC_PIN_W-1:0] s1;
        logic [`AMC_PIN_W-1:0] s2;
        logic [`AMC_PIN_W-1:0] s3;
        logic [`AMC_PIN_W-1:0] flt;
        amc_state_e st;
        amc_cfg_s cfg;
        logic [3:0] drv;
        logic [3:0] pd;
        logic run;
        logic fault_oe;
        logic dc_prot;
        logic cfg_err;
    } amc_regs_s;

    // state of one half-bridge driver
    typedef struct packed {
        logic hs;
        logic ls;
        logic pd;
    } amc_hb_s;

endpackage

// *** amc_half_bridge.sv ***
// amc_half_bridge: gate control of one half-bridge, high-side, low-side and weak pulldown.
// assumes run, drv and pd_req come from logic on ref_clk.
`timescale 1ns/1ns
`include "amc_map.svh"

module amc_half_bridge (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic drv,
    input wire logic pd_req,
    // gate outputs
    output logic hs_on,
    output logic ls_on,
    output logic pd_en
);

    amc_pkg::amc_hb_s r_ff; // registered gate state
    amc_pkg::amc_hb_s nxt_r; // next gate state

    // both switches off unless running; pulldown only while stopped
    always_comb begin
        nxt_r.hs = run & drv;
        nxt_r.ls = run & ~drv;
        nxt_r.pd = ~run & pd_req;
    end

    // gate registers, all off at reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign hs_on = r_ff.hs;
    assign ls_on = r_ff.ls;
    assign pd_en = r_ff.pd;

    // never both switches of the bridge at once
    shoot_through_a: assert property (@(posedge ref_clk) disable iff (rst) !(hs_on && ls_on))
        else $error("half-bridge high and low side both on");

endmodule

// *** amc_ctl_model.sv ***
// amc_ctl_model: system controller and pwm modulator facing the power stage.
// assumes bench commands on ref_clk; the fault line has a pull-up.
`timescale 1ns/1ns

module amc_ctl_model #(
    parameter int HOLD_CYC = 100000
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // bench commands
    input wire logic [2:0] mode_cmd,
    input wire logic run_cmd,
    input wire logic bad_cfg,
    input wire logic [3:0] pwm_cmd,
    // stage pins
    input wire logic fault_n_oe,
    input wire logic fault_n_o,
    output logic fault_n,
    output logic reset_n_pin,
    output logic [2:0] cfg_sel,
    output logic [3:0] pwm_in
);
    int cnt; // cycles left before reset may rise

    always_ff @(posedge ref_clk) begin
        if (rst || !run_cmd || !fault_n) begin
            cnt <= HOLD_CYC;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end

    // reset pin, held high once released until run drops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reset_n_pin <= 1'b0;
        end else begin
            reset_n_pin <= run_cmd && (reset_n_pin || cnt == 0);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || !reset_n_pin || bad_cfg) begin
            cfg_sel <= mode_cmd;
        end
    end

    assign pwm_in = reset_n_pin ? pwm_cmd : 4'h0;
    // open-drain line: driven data while enabled, pull-up level when released
    assign fault_n = fault_n_oe ? fault_n_o : 1'b1;
endmodule

// *** tb_amp_stage_mode_reset_control.sv ***
// tb_amp_stage_mode_reset_control: mode table, fault latch and reset checks.
// assumes amc_top and amc_ctl_model; 25 MHz ref_clk.
`timescale 1ns/1ns

module tb_amp_stage_mode_reset_control;
    localparam int HOLD = 20; // shortened fault-to-release wait
    localparam int LIM = 100; // bound on every wait
    // one mode: inputs and expected outputs
    typedef struct packed {
        logic [2:0] mode;
        logic [3:0] pwm;
        logic [3:0] hs;
        logic [3:0] pd;
        logic dcp;
        logic err;
    } amc_row_s;
    logic ref_clk, rst, run_cmd, bad_cfg, global_fault, overload_fault;
    logic [2:0] mode_cmd, cfg_sel;
    logic [3:0] pwm_cmd, pwm_in, hs_on, ls_on, pd_en;
    logic reset_n_pin, fault_n, fault_n_o, fault_n_oe, dc_prot_en, cfg_err;
    int error_cnt = 0;
    int num_checks = 0;
    // every mode code with pwm A,B high
    amc_row_s rows[8] = '{
        '{3'h0, 4'h3, 4'h3, 4'hF, 1'b1, 1'b0},
        '{3'h1, 4'h3, 4'h9, 4'hF, 1'b1, 1'b0},
        '{3'h2, 4'h3, 4'h3, 4'hF, 1'b0, 1'b0},
        '{3'h3, 4'h3, 4'h1, 4'h3, 1'b1, 1'b0},
        '{3'h4, 4'h3, 4'hF, 4'hF, 1'b1, 1'b0},
        '{3'h5, 4'h3, 4'h3, 4'h0, 1'b1, 1'b0},
        '{3'h6, 4'h3, 4'hF, 4'hF, 1'b0, 1'b0},
        '{3'h7, 4'h3, 4'h0, 4'h0, 1'b0, 1'b1}
    };

    // design and partner
    amc_top amc_top_inst (.ref_clk(ref_clk), .rst(rst), .reset_n_pin(reset_n_pin),
        .cfg_sel0(cfg_sel[0]), .cfg_sel1(cfg_sel[1]), .cfg_sel2(cfg_sel[2]),
        .pwm_in(pwm_in), .global_fault(global_fault), .overload_fault(overload_fault),
        .hs_on(hs_on), .ls_on(ls_on), .pd_en(pd_en), .fault_n_o(fault_n_o),
        .fault_n_oe(fault_n_oe), .dc_prot_en(dc_prot_en), .cfg_err(cfg_err));
    amc_ctl_model #(.HOLD_CYC(HOLD)) amc_ctl_model_inst (.ref_clk(ref_clk), .rst(rst),
        .mode_cmd(mode_cmd), .run_cmd(run_cmd), .bad_cfg(bad_cfg), .pwm_cmd(pwm_cmd),
        .fault_n_oe(fault_n_oe), .fault_n_o(fault_n_o), .fault_n(fault_n),
        .reset_n_pin(reset_n_pin), .cfg_sel(cfg_sel), .pwm_in(pwm_in));

    // 40 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one comparison
    task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // wait for high-side gates to reach a value, bounded
    task automatic wait_hs(input logic [3:0] exp);
        int i;
        i = 0;
        while (hs_on !== exp && i < LIM) begin
            @(posedge ref_clk);
            i++;
        end
        chk("hs_on", exp, hs_on);
        if (i == LIM && hs_on !== exp) begin
            test_done();
        end
        repeat (2) @(posedge ref_clk);
    endtask

    // hold the stage in reset with new pins
    task automatic go_hold(input logic [2:0] m, input logic [3:0] p);
        run_cmd <= 1'b0;
        mode_cmd <= m;
        pwm_cmd <= p;
        repeat (12) @(posedge ref_clk);
    endtask

    // release reset and wait for the pin, bounded
    task automatic go_run();
        int i;
        i = 0;
        run_cmd <= 1'b1;
        while (reset_n_pin !== 1'b1 && i < LIM) begin
            @(posedge ref_clk);
            i++;
        end
        if (reset_n_pin !== 1'b1) begin
            chk("reset_n_pin", 4'h1, reset_n_pin);
            test_done();
        end
        repeat (6) @(posedge ref_clk);
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        run_cmd = 1'b0;
        bad_cfg = 1'b0;
        global_fault = 1'b0;
        overload_fault = 1'b0;
        mode_cmd = 3'h0;
        pwm_cmd = 4'h0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk("hs_on reset", 4'h0, hs_on);
        chk("fault_n_oe reset", 4'h0, fault_n_oe);
        $display("test reset done");
        // mode table
        foreach (rows[r]) begin
            go_hold(rows[r].mode, rows[r].pwm);
            chk("pd_en hold", rows[r].pd, pd_en);
            chk("ls_on hold", 4'h0, ls_on);
            go_run();
            wait_hs(rows[r].hs);
            chk("ls_on run", rows[r].err ? 4'h0 : ~rows[r].hs, ls_on);
            chk("pd_en run", 4'h0, pd_en);
            chk("dc_prot_en", {3'h0, rows[r].dcp}, dc_prot_en);
            chk("cfg_err", {3'h0, rows[r].err}, cfg_err);
            pwm_cmd <= ~rows[r].pwm;
            wait_hs(rows[r].err ? 4'h0 : ~rows[r].hs);
            $display("test mode %0d done", rows[r].mode);
        end
        // global then overload fault
        for (int f = 0; f < 2; f++) begin
            go_hold(3'h0, 4'h3);
            go_run();
            wait_hs(4'h3);
            global_fault <= (f == 0);
            overload_fault <= (f == 1);
            @(posedge ref_clk);
            global_fault <= 1'b0;
            overload_fault <= 1'b0;
            wait_hs(4'h0);
            chk("fault_n_oe set", 4'h1, fault_n_oe);
            chk("fault_n set", 4'h0, fault_n);
            repeat (10) @(posedge ref_clk);
            chk("fault_n_oe held", 4'h1, fault_n_oe);
            chk("ls_on held", 4'h0, ls_on);
            go_hold(3'h0, 4'h3);
            chk("fault_n in reset", 4'h1, fault_n);
            go_run();
            wait_hs(4'h3);
            chk("fault_n_oe cleared", 4'h0, fault_n_oe);
            $display("test fault %0d done", f);
        end
        // fault ignored in reset, mode frozen in run while the mode pins change
        go_hold(3'h6, 4'h3);
        global_fault <= 1'b1;
        repeat (5) @(posedge ref_clk);
        chk("fault_n_oe hold", 4'h0, fault_n_oe);
        global_fault <= 1'b0;
        go_run();
        wait_hs(4'hF);
        bad_cfg <= 1'b1;
        mode_cmd <= 3'h5;
        pwm_cmd <= 4'h1;
        wait_hs(4'h5);
        chk("cfg_err frozen", 4'h0, cfg_err);
        bad_cfg <= 1'b0;
        $display("test frozen mode done");
        // synchronous reset in mid-run drops the high-side gates and leaves the fault line released
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk("hs_on mid reset", 4'h0, hs_on);
        chk("fault_n_oe mid reset", 4'h0, fault_n_oe);
        $display("test mid reset done");
        test_done();
    end
endmodule
